/* src/dac_mode_cfg.svh */
// Contract
// R1 - Left and right 8-bit attenuation registers, 0 to -120 dB plus mute, default 0 dB.
// R2 - Attenuation load enable bit, reset disabled, only in multi-bit sample mode.
// R3 - 3-bit input format field, default 24-bit I2S, filtered and bypass modes.
// R4 - De-emphasis rate field and enable bit, both default disabled.
// R5 - In one-bit stream mode the de-emphasis rate field selects FIR performance.
// R6 - Soft mute bit, default disabled, effective only in multi-bit sample mode.
// R7 - Attenuation step rate field: 1, 1/2, 1/4, 1/8 of fs, default 1.
// R8 - Converter operation bit enables conversion in all modes, default enabled.
// R9 - Bypass stereo select, default mono, effective only with filter bypassed.
// R10 - Rolloff select, default sharp, multi-bit sample mode only.
// R11 - Infinite-zero mute enable, default off, multi-bit and bypass modes.
// R12 - System reset bit, default normal operation, all modes.
// R13 - One-bit stream enable, default off; multi-bit data until set.
// R14 - Filter bypass bit, default internal filter enabled.
// R15 - Mono bit default stereo; source select default left, all modes.
// R16 - Oversampling rate field: 64, 128 or 32 times fs, default 64.
// R17 - In one-bit stream mode oversampling field selects FIR operation rate.
// R18 - Multi-bit zero output enable, default enabled, filtered and bypass modes.
// R19 - 2-bit stream zero output enable, default disabled, stream mode only.
// R20 - Read-only zero flags per channel, 1 when zero detected.
// R21 - Read-only 5-bit device identifier for time-division addressing.
// R22 - Level is 0.5 dB times code minus 255; codes 0 to 14 mute.
// R23 - With load bit clear, applied attenuation holds and new writes ignored.
// R24 - Reserved bits read zero and writes to them have no effect.
`ifndef DAC_MODE_CFG_SVH
`define DAC_MODE_CFG_SVH

// ----------------------------------------
// register indices
// ----------------------------------------
`define ADDR_LEFT_ATTEN    7'h10
`define ADDR_RIGHT_ATTEN   7'h11
`define ADDR_FORMAT_MUTE   7'h12
`define ADDR_FILTER_PHASE  7'h13
`define ADDR_MODE_RESET    7'h14
`define ADDR_ZERO_OUTPUT   7'h15
`define ADDR_ZERO_STATUS   7'h16
`define ADDR_DEVICE_IDENT  7'h17

// ----------------------------------------
// reset values and writable masks
// ----------------------------------------
`define RST_ATTEN          8'hFF
`define RST_FORMAT_MUTE    8'h50
`define RST_FILTER_PHASE   8'h00
`define RST_MODE_RESET     8'h00
`define RST_ZERO_OUTPUT    8'h01
`define MASK_FILTER_PHASE  8'hF7
`define MASK_MODE_RESET    8'h7F
`define MASK_ZERO_OUTPUT   8'h07

// ----------------------------------------
// levels and counts
// ----------------------------------------
`define ATTEN_MUTE_TOP     8'h0E
`define ATTEN_FULL         8'hFF
`define ZERO_RUN_SAMPLES   11'h400

`endif

/* src/dac_mode_pkg.sv */
`default_nettype none

package dac_mode_pkg;

  // mode controls delivered to the audio datapath
  typedef struct packed {
    logic [2:0] input_format_select;
    logic       deemph_enable;
    logic [1:0] deemph_rate_select;
    logic [1:0] fir_perf_select;
    logic       output_phase_invert;
    logic       converter_operation_control;
    logic       bypass_stereo_select;
    logic       rolloff_select;
    logic       system_soft_reset;
    logic       one_bit_stream_mode;
    logic       filter_bypass_enable;
    logic       mono_enable;
    logic       mono_source_select;
    logic [1:0] oversampling_rate_select;
    logic [1:0] fir_rate_select;
    logic       multibit_zero_output_enable;
    logic [1:0] stream_zero_output_enable;
  } mode_ctrl_t;

  // per-channel sample seen by the zero detector
  typedef struct packed {
    logic        valid;
    logic [23:0] data;
  } sample_t;

endpackage

`default_nettype wire

/* src/atten_ramp.sv */
`timescale 1ns/10ps
`default_nettype none
`include "dac_mode_cfg.svh"

module atten_ramp (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       resetn,
  // control
  input  wire logic       step_en,
  input  wire logic       hold_full,
  input  wire logic [7:0] target,
  // applied level
  output logic      [7:0] level,
  output logic            level_mute
);

  wire logic going_down = level > target;
  wire logic going_up   = level < target;

  // one code per step keeps the gain change free of zipper jumps
  always_ff @(posedge core_clk) begin
    if (!resetn || hold_full) begin
      level <= `ATTEN_FULL;
    end else if (step_en && going_down) begin
      level <= level - 8'h01; // R7
    end else if (step_en && going_up) begin
      level <= level + 8'h01; // R7
    end
  end

  assign level_mute = (level <= `ATTEN_MUTE_TOP); // R22

endmodule // atten_ramp
`default_nettype wire

/* src/zero_run_detect.sv */
`timescale 1ns/10ps
`default_nettype none
`include "dac_mode_cfg.svh"

module zero_run_detect
  import dac_mode_pkg::*;
(
  // clock and reset
  input  wire logic    core_clk,
  input  wire logic    resetn,
  // samples
  input  wire sample_t sample,
  // status
  output logic         zero_flag
);

  logic [10:0] run_cnt;
  wire  logic  is_zero = (sample.data == 24'h000000);

  // saturating run of consecutive zero samples
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      run_cnt   <= 11'h000;
      zero_flag <= 1'b0;
    end else if (sample.valid) begin
      if (!is_zero) begin
        run_cnt   <= 11'h000;
        zero_flag <= 1'b0;
      end else if (run_cnt != `ZERO_RUN_SAMPLES) begin
        run_cnt <= run_cnt + 11'h001;
      end else begin
        zero_flag <= 1'b1; // R20
      end
    end
  end

endmodule // zero_run_detect
`default_nettype wire

/* src/dac_mode_regs.sv */
`timescale 1ns/10ps
`default_nettype none
`include "dac_mode_cfg.svh"

module dac_mode_regs
  import dac_mode_pkg::*;
#(
  // arbitrary neutral identifier value
  parameter logic [4:0] DEVICE_IDENT = 5'h00
) (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       resetn,
  // register access from the serial control engine
  input  wire logic [6:0] reg_addr,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            reg_rdata_valid,
  // audio datapath side
  input  wire logic       sample_strobe,
  input  wire sample_t    left_sample,
  input  wire sample_t    right_sample,
  output var mode_ctrl_t  mode_ctrl,
  output logic      [7:0] left_atten_level,
  output logic      [7:0] right_atten_level,
  output logic            left_atten_mute,
  output logic            right_atten_mute,
  output logic            left_zero_mute,
  output logic            right_zero_mute
);

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  logic [7:0] left_attenuation;
  logic [7:0] right_attenuation;
  logic [7:0] format_mute_control;
  logic [7:0] filter_phase_control;
  logic [7:0] mode_reset_control;
  logic [7:0] zero_output_control;
  logic [7:0] left_target;
  logic [7:0] right_target;
  logic [2:0] step_div;
  wire logic [1:0] zero_flags;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  wire logic wr_left   = reg_write && (reg_addr == `ADDR_LEFT_ATTEN);
  wire logic wr_right  = reg_write && (reg_addr == `ADDR_RIGHT_ATTEN);
  wire logic wr_format = reg_write && (reg_addr == `ADDR_FORMAT_MUTE);
  wire logic wr_filter = reg_write && (reg_addr == `ADDR_FILTER_PHASE);
  wire logic wr_mode   = reg_write && (reg_addr == `ADDR_MODE_RESET);
  wire logic wr_zero   = reg_write && (reg_addr == `ADDR_ZERO_OUTPUT);

  // ----------------------------------------
  // field views
  // ----------------------------------------
  wire logic       atten_load_enable           = format_mute_control[7];
  wire logic [2:0] input_format_select         = format_mute_control[6:4];
  wire logic [1:0] deemph_rate_select          = format_mute_control[3:2];
  wire logic       deemph_enable               = format_mute_control[1];
  wire logic       soft_mute_enable            = format_mute_control[0];
  wire logic       output_phase_invert         = filter_phase_control[7];
  wire logic [1:0] atten_step_rate             = filter_phase_control[6:5];
  wire logic       converter_operation_control = filter_phase_control[4];
  wire logic       bypass_stereo_select        = filter_phase_control[2];
  wire logic       rolloff_select              = filter_phase_control[1];
  wire logic       infinite_zero_mute_enable   = filter_phase_control[0];
  wire logic       system_soft_reset           = mode_reset_control[6];
  wire logic       one_bit_stream_mode         = mode_reset_control[5];
  wire logic       filter_bypass_enable        = mode_reset_control[4];
  wire logic       mono_enable                 = mode_reset_control[3];
  wire logic       mono_source_select          = mode_reset_control[2];
  wire logic [1:0] oversampling_rate_select    = mode_reset_control[1:0];
  wire logic [1:0] stream_zero_output_enable   = zero_output_control[2:1];
  wire logic       multibit_zero_output_enable = zero_output_control[0];

  wire logic multibit_mode = !one_bit_stream_mode;           // R13
  wire logic filtered_mode = multibit_mode && !filter_bypass_enable;

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  // reserved bits are masked on write so they always read zero
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      left_attenuation     <= `RST_ATTEN;        // R1
      right_attenuation    <= `RST_ATTEN;        // R1
      format_mute_control  <= `RST_FORMAT_MUTE;  // R2
      filter_phase_control <= `RST_FILTER_PHASE; // R8
      mode_reset_control   <= `RST_MODE_RESET;   // R12
      zero_output_control  <= `RST_ZERO_OUTPUT;  // R18
    end else begin
      if (wr_left) begin
        left_attenuation <= reg_wdata;
      end
      if (wr_right) begin
        right_attenuation <= reg_wdata;
      end
      if (wr_format) begin
        format_mute_control <= reg_wdata;
      end
      if (wr_filter) begin
        filter_phase_control <= reg_wdata & `MASK_FILTER_PHASE; // R24
      end
      if (wr_mode) begin
        mode_reset_control <= reg_wdata & `MASK_MODE_RESET; // R24
      end
      if (wr_zero) begin
        zero_output_control <= reg_wdata & `MASK_ZERO_OUTPUT; // R24
      end
    end
  end

  // ----------------------------------------
  // attenuation targets
  // ----------------------------------------
  // targets move only on a write made while loading is enabled
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      left_target  <= `RST_ATTEN;
      right_target <= `RST_ATTEN;
    end else begin
      if (wr_left && atten_load_enable) begin
        left_target <= reg_wdata; // R23
      end
      if (wr_right && atten_load_enable) begin
        right_target <= reg_wdata; // R23
      end
    end
  end

  // ----------------------------------------
  // step rate divider
  // ----------------------------------------
  wire logic [2:0] step_wrap = 3'(({1'b0, atten_step_rate} == 3'h0) ? 3'h0 :
                                  (atten_step_rate == 2'h1) ? 3'h1 :
                                  (atten_step_rate == 2'h2) ? 3'h3 : 3'h7);
  wire logic       step_en   = sample_strobe && (step_div == 3'h0); // R7

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      step_div <= 3'h0;
    end else if (sample_strobe) begin
      step_div <= (step_div >= step_wrap) ? 3'h0 : step_div + 3'h1;
    end
  end

  // ----------------------------------------
  // per-channel attenuation and zero detect
  // ----------------------------------------
  // stream mode and soft reset bypass the attenuator entirely
  wire logic       hold_full       = one_bit_stream_mode || system_soft_reset; // R2
  wire logic [7:0] eff_target [2];
  wire logic [7:0] level      [2];
  wire logic       level_mute [2];
  wire sample_t    samples    [2];

  assign samples[0] = left_sample;
  assign samples[1] = right_sample;
  assign eff_target[0] = soft_mute_enable ? 8'h00 : left_target;  // R6
  assign eff_target[1] = soft_mute_enable ? 8'h00 : right_target; // R6

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      atten_ramp u_ramp (
        .core_clk   (core_clk),
        .resetn     (resetn),
        .step_en    (step_en),
        .hold_full  (hold_full),
        .target     (eff_target[ch]),
        .level      (level[ch]),
        .level_mute (level_mute[ch])
      );
      zero_run_detect u_zero (
        .core_clk  (core_clk),
        .resetn    (resetn),
        .sample    (samples[ch]),
        .zero_flag (zero_flags[ch])
      );
    end
  endgenerate

  assign left_atten_level  = level[0];
  assign right_atten_level = level[1];
  assign left_atten_mute   = level_mute[0];
  assign right_atten_mute  = level_mute[1];

  // infinite-zero mute is not offered in stream mode
  wire logic izm_allowed = infinite_zero_mute_enable && multibit_mode; // R11

  // ----------------------------------------
  // mode outputs
  // ----------------------------------------
  mode_ctrl_t next_mode_ctrl;

  always_comb begin
    next_mode_ctrl = '0;
    next_mode_ctrl.input_format_select         = input_format_select; // R3
    next_mode_ctrl.deemph_enable               = deemph_enable && filtered_mode; // R4
    next_mode_ctrl.deemph_rate_select          = multibit_mode ? deemph_rate_select : 2'h0; // R4
    next_mode_ctrl.fir_perf_select             = one_bit_stream_mode ? deemph_rate_select : 2'h0; // R5
    next_mode_ctrl.output_phase_invert         = output_phase_invert;
    next_mode_ctrl.converter_operation_control = converter_operation_control; // R8
    next_mode_ctrl.bypass_stereo_select        = bypass_stereo_select &&
                                                 filter_bypass_enable && multibit_mode; // R9
    next_mode_ctrl.rolloff_select              = rolloff_select && filtered_mode; // R10
    next_mode_ctrl.system_soft_reset           = system_soft_reset; // R12
    next_mode_ctrl.one_bit_stream_mode         = one_bit_stream_mode; // R13
    next_mode_ctrl.filter_bypass_enable        = filter_bypass_enable && multibit_mode; // R14
    next_mode_ctrl.mono_enable                 = mono_enable; // R15
    next_mode_ctrl.mono_source_select          = mono_source_select; // R15
    next_mode_ctrl.oversampling_rate_select    = multibit_mode ?
                                                 oversampling_rate_select : 2'h0; // R16
    next_mode_ctrl.fir_rate_select             = one_bit_stream_mode ?
                                                 oversampling_rate_select : 2'h0; // R17
    next_mode_ctrl.multibit_zero_output_enable = multibit_zero_output_enable &&
                                                 multibit_mode; // R18
    next_mode_ctrl.stream_zero_output_enable   = one_bit_stream_mode ?
                                                 stream_zero_output_enable : 2'h0; // R19
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      mode_ctrl       <= '0;
      left_zero_mute  <= 1'b0;
      right_zero_mute <= 1'b0;
    end else begin
      mode_ctrl       <= next_mode_ctrl;
      left_zero_mute  <= izm_allowed && zero_flags[0]; // R11
      right_zero_mute <= izm_allowed && zero_flags[1]; // R11
    end
  end

  // ----------------------------------------
  // readback
  // ----------------------------------------
  wire logic [7:0] rd_mux =
    (reg_addr == `ADDR_LEFT_ATTEN)   ? left_attenuation :
    (reg_addr == `ADDR_RIGHT_ATTEN)  ? right_attenuation :
    (reg_addr == `ADDR_FORMAT_MUTE)  ? format_mute_control :
    (reg_addr == `ADDR_FILTER_PHASE) ? filter_phase_control :
    (reg_addr == `ADDR_MODE_RESET)   ? mode_reset_control :
    (reg_addr == `ADDR_ZERO_OUTPUT)  ? zero_output_control :
    (reg_addr == `ADDR_ZERO_STATUS)  ? {6'h00, zero_flags} : // R20
    (reg_addr == `ADDR_DEVICE_IDENT) ? {3'h0, DEVICE_IDENT} : // R21
    8'h00;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      reg_rdata       <= 8'h00;
      reg_rdata_valid <= 1'b0;
    end else begin
      reg_rdata_valid <= reg_read;
      if (reg_read) begin
        reg_rdata <= rd_mux;
      end
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence s_left_write_locked;
    wr_left && !atten_load_enable;
  endsequence

  property p_target_hold;
    s_left_write_locked |=> $stable(left_target);
  endproperty
  a_target_hold: assert property (p_target_hold) // R23
    else $error("left target moved while load disabled");

  property p_target_load;
    wr_right && atten_load_enable |=> right_target == $past(reg_wdata);
  endproperty
  a_target_load: assert property (p_target_load) // R2
    else $error("right target not loaded on enabled write");

  property p_step_gate;
    !step_en && !hold_full |=> $stable(left_atten_level);
  endproperty
  a_step_gate: assert property (p_step_gate) // R7
    else $error("left level moved without a step enable");

  property p_mute_range;
    left_atten_level <= 8'h0E |-> left_atten_mute;
  endproperty
  a_mute_range: assert property (p_mute_range) // R22
    else $error("code at or below 14 not reported as mute");

  property p_mute_edge;
    left_atten_level == 8'h0F |-> !left_atten_mute;
  endproperty
  a_mute_edge: assert property (p_mute_edge) // R22
    else $error("code 15 reported as mute");

  property p_reserved_read;
    reg_read && reg_addr == `ADDR_ZERO_OUTPUT |=> reg_rdata_valid && reg_rdata[7:3] == 5'h00;
  endproperty
  a_reserved_read: assert property (p_reserved_read) // R24
    else $error("reserved bits of zero output register not zero");

  property p_fir_perf;
    one_bit_stream_mode |=> mode_ctrl.fir_perf_select == $past(deemph_rate_select)
                            && mode_ctrl.deemph_rate_select == 2'h0;
  endproperty
  a_fir_perf: assert property (p_fir_perf) // R5
    else $error("stream mode did not redirect de-emphasis rate field");

  property p_fir_rate;
    one_bit_stream_mode |=> mode_ctrl.fir_rate_select == $past(oversampling_rate_select);
  endproperty
  a_fir_rate: assert property (p_fir_rate) // R17
    else $error("stream mode did not redirect oversampling field");

  property p_ident_read;
    reg_read && reg_addr == `ADDR_DEVICE_IDENT |=> reg_rdata == {3'h0, DEVICE_IDENT};
  endproperty
  a_ident_read: assert property (p_ident_read) // R21
    else $error("identifier readback wrong");

  sequence s_soft_mute_steady;
    soft_mute_enable && multibit_mode && !system_soft_reset;
  endsequence

  property p_soft_mute_down;
    s_soft_mute_steady ##1 s_soft_mute_steady |-> left_atten_level <= $past(left_atten_level);
  endproperty
  a_soft_mute_down: assert property (p_soft_mute_down) // R6
    else $error("level rose during soft mute");

  property p_stream_full;
    one_bit_stream_mode |=> left_atten_level == 8'hFF && right_atten_level == 8'hFF;
  endproperty
  a_stream_full: assert property (p_stream_full) // R13
    else $error("attenuation active in stream mode");

endmodule // dac_mode_regs
`default_nettype wire

/* tb/host_model.sv */
`timescale 1ns/10ps
`default_nettype none

module host_model (
  // clock
  input  wire logic       core_clk,
  // request
  output logic      [6:0] reg_addr,
  output logic            reg_write,
  output logic            reg_read,
  output logic      [7:0] reg_wdata,
  // answer
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rdata_valid
);
  initial begin
    reg_addr = 7'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_wdata = 8'h00;
  end

  // idle bus shows inverted values, so a stale capture cannot pass for data
  task automatic xfer(input logic wr, input logic [6:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge core_clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_write = wr;
    reg_read = !wr;
    @(posedge core_clk);
    #1;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
    // answer must stand just after the taking edge, one cycle after the request is driven
    q = (reg_rdata_valid === 1'b1) ? reg_rdata : 8'hXX;
  endtask
endmodule // host_model

`default_nettype wire

/* tb/dac_mode_regs_tb.sv */
`timescale 1ns/10ps
`default_nettype none

module dac_mode_regs_tb;
  import dac_mode_pkg::*;
  // arbitrary identifier value
  localparam logic [4:0] IDENT = 5'h0A;
  logic       core_clk;
  logic       resetn;
  logic       sample_strobe;
  logic [23:0] ldat;
  logic [23:0] rdat;
  logic [6:0] reg_addr;
  logic       reg_write;
  logic       reg_read;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic       reg_rdata_valid;
  mode_ctrl_t mode_ctrl;
  logic [7:0] lvl_l;
  logic [7:0] lvl_r;
  logic       mute_l;
  logic       mute_r;
  logic       zm_l;
  logic       zm_r;
  logic [7:0] q;
  int         bad_count = 0;
  int         checks_done = 0;
  wire sample_t ls = {sample_strobe, ldat};
  wire sample_t rs = {sample_strobe, rdat};
  // packed views of the mode outputs, so one byte compare covers several fields
  wire logic [7:0] stream_view = {mode_ctrl.one_bit_stream_mode, mode_ctrl.filter_bypass_enable,
                                  mode_ctrl.mono_enable, mode_ctrl.mono_source_select,
                                  mode_ctrl.oversampling_rate_select,
                                  mode_ctrl.stream_zero_output_enable};
  wire logic [7:0] gate_view = {mode_ctrl.rolloff_select, mode_ctrl.bypass_stereo_select,
                                mode_ctrl.deemph_enable, mode_ctrl.multibit_zero_output_enable,
                                mode_ctrl.output_phase_invert, mode_ctrl.fir_rate_select,
                                mode_ctrl.system_soft_reset};
  wire logic [7:0] path_view = {mode_ctrl.rolloff_select, mode_ctrl.bypass_stereo_select,
                                mode_ctrl.deemph_enable, mode_ctrl.filter_bypass_enable,
                                mode_ctrl.deemph_rate_select, mode_ctrl.fir_perf_select};

  dac_mode_regs #(.DEVICE_IDENT(IDENT)) dac_mode_regs_i (
    .core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid),
    .sample_strobe(sample_strobe), .left_sample(ls), .right_sample(rs),
    .mode_ctrl(mode_ctrl), .left_atten_level(lvl_l), .right_atten_level(lvl_r),
    .left_atten_mute(mute_l), .right_atten_mute(mute_r),
    .left_zero_mute(zm_l), .right_zero_mute(zm_r));

  host_model host_model_i (
    .core_clk(core_clk), .reg_addr(reg_addr), .reg_write(reg_write),
    .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rdata_valid(reg_rdata_valid));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host_model_i.xfer(1'b1, a, d, q);
  endtask

  task automatic rdc(input logic [6:0] a, input logic [7:0] e);
    host_model_i.xfer(1'b0, a, 8'h00, q);
    chk($sformatf("reg %h", a), e, q);
  endtask

  task automatic strobe(input int n);
    repeat (n) begin
      @(posedge core_clk);
      #1;
      sample_strobe = 1'b1;
      @(posedge core_clk);
      #1;
      sample_strobe = 1'b0;
    end
  endtask

  task automatic settle();
    repeat (2) @(posedge core_clk);
    #1;
  endtask

  task automatic end_sim();
    $display("counts: %0d checks, %0d bad", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_defaults();
    rdc(7'h10, 8'hFF);
    rdc(7'h11, 8'hFF);
    rdc(7'h12, 8'h50);
    rdc(7'h13, 8'h00);
    rdc(7'h14, 8'h00);
    rdc(7'h15, 8'h01);
    rdc(7'h16, 8'h00);
    rdc(7'h17, {3'b000, IDENT});
    rdc(7'h20, 8'h00);
    chk("format", 8'h05, {5'h00, mode_ctrl.input_format_select});
    chk("default stream view", 8'h00, stream_view);
    chk("default gate view", 8'h10, gate_view);
    $display("defaults done");
  endtask

  task automatic t_masks();
    wr(7'h13, 8'hFF);
    wr(7'h14, 8'hFF);
    wr(7'h15, 8'hFF);
    wr(7'h16, 8'hFF);
    wr(7'h17, 8'hFF);
    rdc(7'h13, 8'hF7);
    rdc(7'h14, 8'h7F);
    rdc(7'h15, 8'h07);
    rdc(7'h16, 8'h00);
    rdc(7'h17, {3'b000, IDENT});
    chk("ope", 8'h01, {7'h00, mode_ctrl.converter_operation_control});
    chk("stream view", 8'hB3, stream_view);
    chk("stream gate view", 8'h0F, gate_view);
    wr(7'h13, 8'h00);
    wr(7'h14, 8'h00);
    wr(7'h15, 8'h01);
    $display("masks done");
  endtask

  task automatic t_atten();
    wr(7'h10, 8'hF0);
    strobe(4);
    chk("held level", 8'hFF, lvl_l);
    wr(7'h12, 8'hD0);
    wr(7'h10, 8'hFD);
    wr(7'h11, 8'h0F);
    strobe(1);
    chk("left step1", 8'hFE, lvl_l);
    strobe(1);
    chk("left step2", 8'hFD, lvl_l);
    strobe(238);
    chk("left hold", 8'hFD, lvl_l);
    chk("mute l", 8'h00, {7'h00, mute_l});
    chk("right 0F", 8'h0F, lvl_r);
    chk("mute 0F", 8'h00, {7'h00, mute_r});
    wr(7'h11, 8'h0E);
    strobe(1);
    chk("right 0E", 8'h0E, lvl_r);
    chk("mute 0E", 8'h01, {7'h00, mute_r});
    $display("atten done");
  endtask

  task automatic t_rate_mute();
    wr(7'h13, 8'h60);
    wr(7'h11, 8'hFF);
    strobe(16);
    chk("rate 1/8", 8'h10, lvl_r);
    wr(7'h13, 8'h00);
    wr(7'h12, 8'hD1);
    strobe(16);
    chk("soft mute", 8'hED, lvl_l);
    wr(7'h12, 8'hD0);
    $display("rate and mute done");
  endtask

  task automatic t_modes();
    wr(7'h14, 8'h40);
    settle();
    chk("system_soft_reset level", 8'hFF, lvl_l);
    chk("system_soft_reset bit", 8'h01, {7'h00, mode_ctrl.system_soft_reset});
    wr(7'h14, 8'h00);
    wr(7'h12, 8'h88);
    wr(7'h14, 8'h21);
    settle();
    chk("fir perf", 8'h02, {6'h00, mode_ctrl.fir_perf_select});
    chk("fir rate", 8'h01, {6'h00, mode_ctrl.fir_rate_select});
    chk("stream", 8'h01, {7'h00, mode_ctrl.one_bit_stream_mode});
    wr(7'h13, 8'h06);
    wr(7'h12, 8'h8A);
    wr(7'h14, 8'h10);
    settle();
    chk("bypass path", 8'h58, path_view);
    chk("bypass format", 8'h00, {5'h00, mode_ctrl.input_format_select});
    wr(7'h14, 8'h00);
    settle();
    chk("filtered path", 8'hA8, path_view);
    wr(7'h12, 8'hD0);
    $display("modes done");
  endtask

  task automatic t_zero();
    wr(7'h13, 8'h01);
    ldat = 24'h000000;
    strobe(1026);
    rdc(7'h16, 8'h01);
    chk("zero mute l", 8'h01, {7'h00, zm_l});
    chk("zero mute r", 8'h00, {7'h00, zm_r});
    ldat = 24'h000001;
    strobe(1);
    rdc(7'h16, 8'h00);
    $display("zero done");
  endtask

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  initial begin
    #100000;
    bad_count++;
    $display("watchdog expired");
    end_sim();
  end

  initial begin
    resetn = 1'b0;
    sample_strobe = 1'b0;
    ldat = 24'h000001;
    rdat = 24'h000001;
    repeat (4) @(posedge core_clk);
    #1;
    resetn = 1'b1;
    t_defaults();
    t_masks();
    t_atten();
    t_rate_mute();
    t_modes();
    t_zero();
    end_sim();
  end
endmodule // dac_mode_regs_tb

`default_nettype wire
